//--- inc/pce_pkg.sv
/*
  Package for the pin change edge enable block: register indices,
  reset values, field positions and the bus carrier types.
  Assumes a 32-bit AXI4-Lite bus; a register's byte address is its
  index times four.
*/
package pce_pkg;

  // Bus widths
  localparam int AXI_AW = 16;           // Byte address width
  localparam int IDX_W  = 14;           // Word index width

  // Register indices (byte address = index * 4)
  localparam logic [13:0] IDX_A_FLAG = 14'h0F0A;  // Port A per-pin status
  localparam logic [13:0] IDX_A_RISE = 14'h0F0C;  // Port A rising enables
  localparam logic [13:0] IDX_B_FLAG = 14'h0F12;  // Port B per-pin status
  localparam logic [13:0] IDX_B_FALL = 14'h0F13;  // Port B falling enables
  localparam logic [13:0] IDX_B_RISE = 14'h0F14;  // Port B rising enables
  localparam logic [13:0] IDX_C_FLAG = 14'h0F1A;  // Port C per-pin status
  localparam logic [13:0] IDX_C_FALL = 14'h0F1B;  // Port C falling enables
  localparam logic [13:0] IDX_C_RISE = 14'h0F1C;  // Port C rising enables
  localparam logic [13:0] IDX_E_FLAG = 14'h0F27;  // Port E per-pin status
  localparam logic [13:0] IDX_E_FALL = 14'h0F28;  // Port E falling enable
  localparam logic [13:0] IDX_E_RISE = 14'h0F29;  // Port E rising enable
  localparam logic [13:0] IDX_IRQ_ST = 14'h0F30;  // Interrupt status
  localparam logic [13:0] IDX_IRQ_MK = 14'h0F31;  // Interrupt mask

  // Field positions
  localparam int E_PIN_POS = 3;         // Only port E pin implemented
  localparam int IRQ_A     = 0;         // Interrupt status bit, port A
  localparam int IRQ_B     = 1;         // Port B
  localparam int IRQ_C     = 2;         // Port C
  localparam int IRQ_E     = 3;         // Port E

  // Reset values
  localparam logic [7:0] RST_EN   = 8'h00;  // Edge enables
  localparam logic [7:0] RST_FLAG = 8'h00;  // Per-pin status
  localparam logic [3:0] RST_IRQ  = 4'h0;   // Interrupt status and mask

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Write request handed from the bus slave to the register file
  typedef struct packed {
    logic [13:0] idx;                   // Word index
    logic [7:0]  data;                  // Byte lane 0
    logic        lane0;                 // Byte lane 0 strobe
  } pce_wreq_t;

endpackage : pce_pkg

//--- sim/pce_pin_model.sv
/*
  Far-side model: the circuitry that drives the port pins.
  Assumes the bench calls drive() right after a rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module pce_pin_model (
  // Clock
  input  wire logic  ref_clk,
  // Pins toward the block
  output logic [7:0] port_a_pins,
  output logic [7:0] port_b_pins,
  output logic [7:0] port_c_pins,
  output logic       port_e_pin_three
);
  // Pins idle low
  initial {port_a_pins, port_b_pins, port_c_pins, port_e_pin_three} = 25'h0;

  // New level on one port, then held long enough for one event per change
  task automatic drive(input int p, input logic [7:0] v);
    @(posedge ref_clk);
    case (p)
      0: port_a_pins <= v;
      1: port_b_pins <= v;
      2: port_c_pins <= v;
      default: port_e_pin_three <= v[0];
    endcase
    repeat (6) @(posedge ref_clk);
  endtask : drive
endmodule : pce_pin_model
`default_nettype wire

//--- sim/pce_top_asserts.sv
/*
  Port-level checker for the pin change edge enable top.
  Assumes it is bound onto pce_top; one clock, reset active low.
*/
`timescale 1ns/10ps
`default_nettype none
module pce_top_asserts
  import pce_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Pins
  input  wire logic [7:0]  port_a_pins,
  input  wire logic [7:0]  port_b_pins,
  input  wire logic [7:0]  port_c_pins,
  input  wire logic        port_e_pin_three,
  // Register bus
  input  wire logic        s_awvalid,
  input  wire logic        s_awready,
  input  wire logic        s_wvalid,
  input  wire logic        s_wready,
  input  wire logic [1:0]  s_bresp,
  input  wire logic        s_bvalid,
  input  wire logic        s_bready,
  input  wire logic        s_arvalid,
  input  wire logic        s_arready,
  input  wire logic [31:0] s_rdata,
  input  wire logic        s_rvalid,
  input  wire logic        s_rready,
  // Interrupt
  input  wire logic        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic [24:0] pins_now;                 // All pins as one word
  logic [24:0] pins_ff, nxt_pins;        // Previous pin sample
  logic [3:0]  pin_age_ff, nxt_pin_age;  // Cycles since a pin moved

  assign pins_now = {port_a_pins, port_b_pins, port_c_pins, port_e_pin_three};

  // Ages saturate, so a long quiet spell never wraps back to look recent
  always_comb begin
    nxt_pins    = pins_now;
    nxt_pin_age = (pins_now != pins_ff) ? 4'h0 : pin_age_ff + {3'h0, pin_age_ff != 4'hF};
  end

  // Age registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_ff    <= 25'h0;
      pin_age_ff <= 4'hF;
    end else begin
      pins_ff    <= nxt_pins;
      pin_age_ff <= nxt_pin_age;
    end
  end

  property p_wr_resp; s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_b_hold; s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rd_resp; s_arvalid && s_arready |=> s_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_r_hold; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_r_high; s_rvalid |-> s_rdata[31:8] == 24'h0; endproperty
  a_r_high: assert property (p_r_high) else $error("upper read bits set");
  property p_w_busy; s_bvalid |-> !s_awready && !s_wready; endproperty
  a_w_busy: assert property (p_w_busy) else $error("write taken while answering");
  property p_ar_busy; s_rvalid |-> !s_arready; endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read taken while answering");
  // A register write moves irq at the edge that raises bvalid, so bvalid still stands
  property p_irq_cause; $rose(irq) |-> pin_age_ff <= 4'h6 || s_bvalid; endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
  property p_irq_sticky; $fell(irq) |-> s_bvalid; endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq fell without write");

  c_wr: cover property (s_bvalid && s_bready);
  c_rd: cover property (s_rvalid && s_rready);
  c_irq: cover property ($rose(irq));
endmodule : pce_top_asserts
`default_nettype wire

//--- sim/tb_pin_change_edge_enable.sv
/*
  Self-checking bench for pce_top: register access, edge detection,
  strap blocking, mask and sticky status.
  Assumes pce_pin_model drives the pins; the checker is bound below.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED at %0t: got %0h want %0h", $time, (g), (e)); end end
module tb_pin_change_edge_enable
  import pce_pkg::*;
;
  logic        ref_clk, rst_n, irq; // Clock, reset, irq
  logic        reset_pin_function_config, low_voltage_programming_config; // Straps
  logic [7:0]  port_a_pins, port_b_pins, port_c_pins; // Pins
  logic        port_e_pin_three; // Port E pin
  logic [15:0] s_awaddr, s_araddr; // Addresses
  logic [31:0] s_wdata, s_rdata; // Data
  logic [3:0]  s_wstrb; // Byte strobes
  logic [1:0]  s_bresp, s_rresp; // Responses
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  int          error_cnt, checks_done, i; // Counters
  logic [13:0] idx_tab [13] = '{IDX_A_RISE, IDX_B_FALL, IDX_B_RISE, IDX_C_FALL,
    IDX_C_RISE, IDX_E_FALL, IDX_E_RISE, IDX_A_FLAG, IDX_B_FLAG, IDX_C_FLAG,
    IDX_E_FLAG, IDX_IRQ_ST, IDX_IRQ_MK};                              // All registers
  logic [7:0]  wmask [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h08, 8'h08}; // Bits

  pce_top pce_top_inst (.ref_clk, .rst_n, .port_a_pins, .port_b_pins, .port_c_pins,
    .port_e_pin_three, .reset_pin_function_config, .low_voltage_programming_config,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .irq);
  pce_pin_model pce_pin_model_inst (.ref_clk, .port_a_pins, .port_b_pins,
    .port_c_pins, .port_e_pin_three);

  always #5 ref_clk = ~ref_clk;

  // Verdict; also reached when a wait runs out
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // A wait that used its whole bound ends the run
  task automatic guard(input int n);
    if (n >= 40) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: bus timeout", $time);
      end_of_test();
    end
  endtask : guard

  // Write: address and data together, ready raised late to exercise hold
  task automatic wr(input logic [13:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    s_awaddr  <= {idx, 2'b00};
    s_wdata   <= {24'h0, d};
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_bvalid && s_bready) break;
      if (s_bvalid) s_bready <= 1'b1;
    end
    s_bready <= 1'b0;
    guard(n);
    `CHK(s_bresp, er)
  endtask : wr

  // Read and compare the low byte; upper bits must read zero
  task automatic rd(input logic [13:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    s_araddr  <= {idx, 2'b00};
    s_arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid && s_rready) break;
      if (s_rvalid) s_rready <= 1'b1;
    end
    s_rready <= 1'b0;
    guard(n);
    `CHK(s_rdata, {24'h0, d})
    `CHK(s_rresp, er)
  endtask : rd

  // One port: enables, rise then fall, sticky status, clears
  task automatic port_case(input int p, input logic [13:0] fl, ri, fa,
                           input logic [7:0] rv, fv, xu, xd, st);
    wr(ri, rv, RESP_OKAY);
    if (fa != 14'h0) wr(fa, fv, RESP_OKAY);
    pce_pin_model_inst.drive(p, 8'hFF);
    rd(fl, xu, RESP_OKAY);
    pce_pin_model_inst.drive(p, 8'h00);
    rd(fl, xd, RESP_OKAY);
    rd(IDX_IRQ_ST, st, RESP_OKAY);
    `CHK(irq, 1'b1)
    wr(fl, 8'h0F, RESP_OKAY);
    rd(fl, xd & 8'h0F, RESP_OKAY);
    wr(fl, 8'h00, RESP_OKAY);
    rd(fl, 8'h00, RESP_OKAY);
    `CHK(irq, 1'b1)
    wr(IDX_IRQ_ST, st, RESP_OKAY);
    `CHK(irq, 1'b0)
  endtask : port_case

  // Main sequence
  initial begin
    {ref_clk, rst_n, error_cnt, checks_done} = '0;
    {reset_pin_function_config, low_voltage_programming_config} = 2'h0;
    {s_awaddr, s_araddr, s_wdata, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    s_wstrb = 4'hF;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    `CHK(irq, 1'b0)
    for (i = 0; i < 13; i++) rd(idx_tab[i], 8'h00, RESP_OKAY);
    for (i = 0; i < 7; i++) begin
      wr(idx_tab[i], 8'hFF, RESP_OKAY);
      rd(idx_tab[i], wmask[i], RESP_OKAY);
    end
    // Lane 0 strobe off: OKAY, nothing written
    s_wstrb <= 4'hE;
    wr(IDX_A_RISE, 8'h00, RESP_OKAY);
    s_wstrb <= 4'hF;
    rd(IDX_A_RISE, 8'hFF, RESP_OKAY);
    wr(14'h0F0B, 8'hFF, RESP_SLVERR);
    rd(14'h0F0B, 8'h00, RESP_SLVERR);
    wr(IDX_IRQ_MK, 8'h0F, RESP_OKAY);
    port_case(1, IDX_B_FLAG, IDX_B_RISE, IDX_B_FALL, 8'h0F, 8'hF0, 8'h0F, 8'hFF, 8'h02);
    port_case(2, IDX_C_FLAG, IDX_C_RISE, IDX_C_FALL, 8'h00, 8'h3C, 8'h00, 8'h3C, 8'h04);
    port_case(0, IDX_A_FLAG, IDX_A_RISE, 14'h0, 8'hA5, 8'h00, 8'hA5, 8'hA5, 8'h01);
    port_case(3, IDX_E_FLAG, IDX_E_RISE, IDX_E_FALL, 8'h00, 8'h08, 8'h00, 8'h08, 8'h08);
    // Either strap alone must hide the port E pin
    for (i = 1; i < 3; i++) begin
      {reset_pin_function_config, low_voltage_programming_config} <= i[1:0];
      repeat (6) @(posedge ref_clk);
      pce_pin_model_inst.drive(3, 8'hFF);
      pce_pin_model_inst.drive(3, 8'h00);
      rd(IDX_E_FLAG, 8'h00, RESP_OKAY);
    end
    // Masked event: status set, irq only once unmasked
    wr(IDX_IRQ_MK, 8'h00, RESP_OKAY);
    pce_pin_model_inst.drive(1, 8'h01);
    `CHK(irq, 1'b0)
    rd(IDX_IRQ_ST, 8'h02, RESP_OKAY);
    wr(IDX_IRQ_MK, 8'h0F, RESP_OKAY);
    `CHK(irq, 1'b1)
    wr(IDX_IRQ_ST, 8'h02, RESP_OKAY);
    `CHK(irq, 1'b0)
    end_of_test();
  end
endmodule : tb_pin_change_edge_enable

bind pce_top pce_top_asserts pce_top_asserts_inst (.ref_clk, .rst_n, .port_a_pins,
  .port_b_pins, .port_c_pins, .port_e_pin_three, .s_awvalid, .s_awready, .s_wvalid,
  .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_rdata,
  .s_rvalid, .s_rready, .irq);
`default_nettype wire

//--- src/pce_axil.sv
/*
  AXI4-Lite slave front end: one write and one read at a time.
  Assumes the register file answers a read index in the same cycle
  and decodes the write request it is handed.
*/
`timescale 1ns/10ps
`default_nettype none
module pce_axil
  import pce_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Write address and data
  input  wire logic [AXI_AW-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  // Write response
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  // Read address and data
  input  wire logic [AXI_AW-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // Register file side
  output pce_wreq_t              wr_req,
  output logic                   wr_en,
  input  wire logic              wr_hit,
  output logic [IDX_W-1:0]       rd_idx,
  output logic                   rd_en,
  input  wire logic              rd_hit,
  input  wire logic [7:0]        rd_data
);

  logic      aw_ff, nxt_aw;             // Address held
  logic      w_ff, nxt_w;               // Data held
  pce_wreq_t req_ff, nxt_req;           // Captured request
  logic      bv_ff, nxt_bv;
  logic [1:0] br_ff, nxt_br;
  logic      rv_ff, nxt_rv;
  logic [1:0] rr_ff, nxt_rr;
  logic [7:0] rd_ff, nxt_rd;

  // Address and data may arrive in either order; no new one during response
  assign s_awready = !aw_ff && !bv_ff;
  assign s_wready  = !w_ff && !bv_ff;
  assign s_arready = !rv_ff;
  assign wr_en     = aw_ff && w_ff && !bv_ff;
  assign rd_en     = s_arvalid && s_arready;
  assign rd_idx    = s_araddr[AXI_AW-1:2];
  assign wr_req    = req_ff;

  // Next state of both channels
  always_comb begin
    nxt_aw  = aw_ff;
    nxt_w   = w_ff;
    nxt_req = req_ff;
    nxt_bv  = bv_ff;
    nxt_br  = br_ff;
    nxt_rv  = rv_ff;
    nxt_rr  = rr_ff;
    nxt_rd  = rd_ff;
    if (s_awvalid && s_awready) begin
      nxt_aw      = 1'b1;
      nxt_req.idx = s_awaddr[AXI_AW-1:2];
    end
    if (s_wvalid && s_wready) begin
      nxt_w         = 1'b1;
      nxt_req.data  = s_wdata[7:0];
      nxt_req.lane0 = s_wstrb[0];
    end
    if (wr_en) begin
      nxt_aw = 1'b0;
      nxt_w  = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bv_ff && s_bready) begin
      nxt_bv = 1'b0;
    end
    if (rd_en) begin
      nxt_rv = 1'b1;
      nxt_rr = rd_hit ? RESP_OKAY : RESP_SLVERR;
      nxt_rd = rd_hit ? rd_data : 8'h00;
    end else if (rv_ff && s_rready) begin
      nxt_rv = 1'b0;
    end
  end

  // Registers only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_ff  <= 1'b0;
      w_ff   <= 1'b0;
      req_ff <= '0;
      bv_ff  <= 1'b0;
      br_ff  <= RESP_OKAY;
      rv_ff  <= 1'b0;
      rr_ff  <= RESP_OKAY;
      rd_ff  <= 8'h00;
    end else begin
      aw_ff  <= nxt_aw;
      w_ff   <= nxt_w;
      req_ff <= nxt_req;
      bv_ff  <= nxt_bv;
      br_ff  <= nxt_br;
      rv_ff  <= nxt_rv;
      rr_ff  <= nxt_rr;
      rd_ff  <= nxt_rd;
    end
  end

  assign s_bvalid = bv_ff;
  assign s_bresp  = br_ff;
  assign s_rvalid = rv_ff;
  assign s_rresp  = rr_ff;
  assign s_rdata  = {24'h000000, rd_ff};

endmodule : pce_axil
`default_nettype wire

//--- src/pce_edge_det.sv
/*
  Per-pin edge detector: synchroniser, previous sample and enable
  gating. One instance per port.
  Assumes asynchronous pin levels and enables on ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module pce_edge_det
  import pce_pkg::*;
#(
  parameter int W = 8                   // Pins on the port
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Pins and controls
  input  wire logic [W-1:0] pin_async,
  input  wire logic [W-1:0] rise_en,
  input  wire logic [W-1:0] fall_en,
  input  wire logic         blocked,
  // One-cycle event per pin
  output logic      [W-1:0] event_out
);

  logic [W-1:0] sync1_ff, sync2_ff;     // Two-stage synchroniser
  logic [W-1:0] prev_ff;                // Last synchronised sample
  logic [W-1:0] ev_ff, nxt_ev;          // Registered events

  // Per-pin edge compare; one event per transition
  for (genvar i = 0; i < W; i++) begin : g_pin
    always_comb begin
      nxt_ev[i] = 1'b0;
      if (!blocked) begin
        nxt_ev[i] = (sync2_ff[i] & ~prev_ff[i] & rise_en[i])
                  | (~sync2_ff[i] & prev_ff[i] & fall_en[i]);
      end
    end
  end

  // Sample keeps tracking while blocked, so unblocking gives no stale edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff  <= '0;
      ev_ff    <= '0;
    end else begin
      sync1_ff <= pin_async;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
      ev_ff    <= nxt_ev;
    end
  end

  assign event_out = ev_ff;

endmodule : pce_edge_det
`default_nettype wire

//--- src/pce_top.sv
/*
  Pin change edge enable block: per-pin rising edge enables for port A,
  rising and falling for ports B, C and E, per-pin status, and one interrupt.
  Assumes asynchronous pins and config straps, AXI4-Lite on ref_clk.
*/
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module pce_top
  import pce_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Port pins, asynchronous
  input  wire logic [7:0]        port_a_pins,
  input  wire logic [7:0]        port_b_pins,
  input  wire logic [7:0]        port_c_pins,
  input  wire logic              port_e_pin_three,
  // Configuration straps, asynchronous
  input  wire logic              reset_pin_function_config,
  input  wire logic              low_voltage_programming_config,
  // AXI4-Lite write address and data
  input  wire logic [AXI_AW-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  // AXI4-Lite read
  input  wire logic [AXI_AW-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // Interrupt, level
  output logic                   irq
);

  // Bus side wires
  pce_wreq_t        wr_req;             // Captured write
  logic             wr_en;              // One-cycle write strobe
  logic             wr_hit;             // Write index decodes
  logic [IDX_W-1:0] rd_idx;             // Read index
  logic             rd_hit;             // Read index decodes
  logic [7:0]       rd_data;            // Read mux result
  logic             wr_ok;              // Write with lane 0 enabled

  // Edge enable registers
  logic [7:0] a_rise_ff, nxt_a_rise;
  logic [7:0] b_fall_ff, nxt_b_fall;
  logic [7:0] b_rise_ff, nxt_b_rise;
  logic [7:0] c_fall_ff, nxt_c_fall;
  logic [7:0] c_rise_ff, nxt_c_rise;
  logic       e_fall_ff, nxt_e_fall;    // Port E pin 3 only
  logic       e_rise_ff, nxt_e_rise;    // Port E pin 3 only

  // Per-pin status registers
  logic [7:0] a_flag_ff, nxt_a_flag;
  logic [7:0] b_flag_ff, nxt_b_flag;
  logic [7:0] c_flag_ff, nxt_c_flag;
  logic       e_flag_ff, nxt_e_flag;

  // Interrupt status, mask and output
  logic [3:0] irq_st_ff, nxt_irq_st;
  logic [3:0] irq_mk_ff, nxt_irq_mk;
  logic       irq_ff, nxt_irq;
  logic [3:0] port_ev;                  // Any event per port

  // Config strap synchroniser
  logic [1:0] cfg_s1_ff, cfg_s2_ff;
  logic       e_blocked;                // Port E pin unavailable

  // Edge events
  logic [7:0] a_ev, b_ev, c_ev;
  logic       e_ev;

  // Bus slave
  pce_axil u_axil (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_req    (wr_req),
    .wr_en     (wr_en),
    .wr_hit    (wr_hit),
    .rd_idx    (rd_idx),
    .rd_en     (),
    .rd_hit    (rd_hit),
    .rd_data   (rd_data)
  );

  // Straps pass two flops before use
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_s1_ff <= 2'h0;
      cfg_s2_ff <= 2'h0;
    end else begin
      cfg_s1_ff <= {reset_pin_function_config, low_voltage_programming_config};
      cfg_s2_ff <= cfg_s1_ff;
    end
  end

  // Either strap takes the port E pin away from change detection
  assign e_blocked = |cfg_s2_ff;

  // Port A: no falling enable exists, tied off
  pce_edge_det #(.W(8)) u_edge_a (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .pin_async (port_a_pins),
    .rise_en   (a_rise_ff),
    .fall_en   (8'h00),
    .blocked   (1'b0),
    .event_out (a_ev)
  );

  // Port B, full coverage
  pce_edge_det #(.W(8)) u_edge_b (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .pin_async (port_b_pins),
    .rise_en   (b_rise_ff),
    .fall_en   (b_fall_ff),
    .blocked   (1'b0),
    .event_out (b_ev)
  );

  // Port C, full coverage
  pce_edge_det #(.W(8)) u_edge_c (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .pin_async (port_c_pins),
    .rise_en   (c_rise_ff),
    .fall_en   (c_fall_ff),
    .blocked   (1'b0),
    .event_out (c_ev)
  );

  // Port E, the single pin 3
  pce_edge_det #(.W(1)) u_edge_e (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .pin_async (port_e_pin_three),
    .rise_en   (e_rise_ff),
    .fall_en   (e_fall_ff),
    .blocked   (e_blocked),
    .event_out (e_ev)
  );

  // Address decode; narrow data sits in lane 0 only
  function automatic logic idx_hit(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_A_FLAG, IDX_A_RISE, IDX_B_FLAG, IDX_B_FALL, IDX_B_RISE,
      IDX_C_FLAG, IDX_C_FALL, IDX_C_RISE, IDX_E_FLAG, IDX_E_FALL,
      IDX_E_RISE, IDX_IRQ_ST, IDX_IRQ_MK: idx_hit = 1'b1;
      default:                            idx_hit = 1'b0;
    endcase
  endfunction : idx_hit

  assign wr_hit = idx_hit(wr_req.idx);
  assign rd_hit = idx_hit(rd_idx);
  assign wr_ok  = wr_en && wr_req.lane0;

  // Read mux; unimplemented bits read zero
  always_comb begin
    case (rd_idx)
      IDX_A_FLAG: rd_data = a_flag_ff;
      IDX_A_RISE: rd_data = a_rise_ff;
      IDX_B_FLAG: rd_data = b_flag_ff;
      IDX_B_FALL: rd_data = b_fall_ff;
      IDX_B_RISE: rd_data = b_rise_ff;
      IDX_C_FLAG: rd_data = c_flag_ff;
      IDX_C_FALL: rd_data = c_fall_ff;
      IDX_C_RISE: rd_data = c_rise_ff;
      IDX_E_FLAG: rd_data = 8'(e_flag_ff) << E_PIN_POS;
      IDX_E_FALL: rd_data = 8'(e_fall_ff) << E_PIN_POS;
      IDX_E_RISE: rd_data = 8'(e_rise_ff) << E_PIN_POS;
      IDX_IRQ_ST: rd_data = {4'h0, irq_st_ff};
      IDX_IRQ_MK: rd_data = {4'h0, irq_mk_ff};
      default:    rd_data = 8'h00;
    endcase
  end

  // Enable registers: plain read/write, one bit per pin
  always_comb begin
    nxt_a_rise = a_rise_ff;
    nxt_b_fall = b_fall_ff;
    nxt_b_rise = b_rise_ff;
    nxt_c_fall = c_fall_ff;
    nxt_c_rise = c_rise_ff;
    nxt_e_fall = e_fall_ff;
    nxt_e_rise = e_rise_ff;
    if (wr_ok) begin
      case (wr_req.idx)
        IDX_A_RISE: nxt_a_rise = wr_req.data;
        IDX_B_FALL: nxt_b_fall = wr_req.data;
        IDX_B_RISE: nxt_b_rise = wr_req.data;
        IDX_C_FALL: nxt_c_fall = wr_req.data;
        IDX_C_RISE: nxt_c_rise = wr_req.data;
        IDX_E_FALL: nxt_e_fall = wr_req.data[E_PIN_POS];
        IDX_E_RISE: nxt_e_rise = wr_req.data[E_PIN_POS];
        default:    ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_rise_ff <= RST_EN;
      b_fall_ff <= RST_EN;
      b_rise_ff <= RST_EN;
      c_fall_ff <= RST_EN;
      c_rise_ff <= RST_EN;
      e_fall_ff <= 1'b0;
      e_rise_ff <= 1'b0;
    end else begin
      a_rise_ff <= nxt_a_rise;
      b_fall_ff <= nxt_b_fall;
      b_rise_ff <= nxt_b_rise;
      c_fall_ff <= nxt_c_fall;
      c_rise_ff <= nxt_c_rise;
      e_fall_ff <= nxt_e_fall;
      e_rise_ff <= nxt_e_rise;
    end
  end

  // Status: writing zero clears a bit, writing one leaves it;
  // an event in the same cycle wins so no edge is lost
  always_comb begin
    nxt_a_flag = a_flag_ff;
    nxt_b_flag = b_flag_ff;
    nxt_c_flag = c_flag_ff;
    nxt_e_flag = e_flag_ff;
    if (wr_ok) begin
      case (wr_req.idx)
        IDX_A_FLAG: nxt_a_flag = a_flag_ff & wr_req.data;
        IDX_B_FLAG: nxt_b_flag = b_flag_ff & wr_req.data;
        IDX_C_FLAG: nxt_c_flag = c_flag_ff & wr_req.data;
        IDX_E_FLAG: nxt_e_flag = e_flag_ff & wr_req.data[E_PIN_POS];
        default:    ;
      endcase
    end
    nxt_a_flag = nxt_a_flag | a_ev;
    nxt_b_flag = nxt_b_flag | b_ev;
    nxt_c_flag = nxt_c_flag | c_ev;
    nxt_e_flag = nxt_e_flag | e_ev;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_flag_ff <= RST_FLAG;
      b_flag_ff <= RST_FLAG;
      c_flag_ff <= RST_FLAG;
      e_flag_ff <= 1'b0;
    end else begin
      a_flag_ff <= nxt_a_flag;
      b_flag_ff <= nxt_b_flag;
      c_flag_ff <= nxt_c_flag;
      e_flag_ff <= nxt_e_flag;
    end
  end

  // Shared change flag per port, sticky, cleared by writing one
  assign port_ev[IRQ_A] = |a_ev;
  assign port_ev[IRQ_B] = |b_ev;
  assign port_ev[IRQ_C] = |c_ev;
  assign port_ev[IRQ_E] = e_ev;

  // Interrupt status and mask; the level output is registered
  always_comb begin
    nxt_irq_st = irq_st_ff;
    nxt_irq_mk = irq_mk_ff;
    if (wr_ok && wr_req.idx == IDX_IRQ_ST) begin
      nxt_irq_st = irq_st_ff & ~wr_req.data[3:0];
    end
    if (wr_ok && wr_req.idx == IDX_IRQ_MK) begin
      nxt_irq_mk = wr_req.data[3:0];
    end
    nxt_irq_st = nxt_irq_st | port_ev;
    nxt_irq    = |(nxt_irq_st & nxt_irq_mk);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_ff <= RST_IRQ;
      irq_mk_ff <= RST_IRQ;
      irq_ff    <= 1'b0;
    end else begin
      irq_st_ff <= nxt_irq_st;
      irq_mk_ff <= nxt_irq_mk;
      irq_ff    <= nxt_irq;
    end
  end

  assign irq = irq_ff;

endmodule : pce_top
`default_nettype wire
